// file: rtl/audio_dsp_core.v
// sample-rate datapath: extend, scale, clip, paced by the instruction budget
// Operation
// - input and output audio samples are 24 bits wide
// - datapath carries four headroom bits above 24-bit audio
// - parameters and data share a 5.23 fixed-point format
// - range is -16 to +16 minus one lsb, one is 0x0800000
// - 24-bit serial inputs are sign-extended to 28 bits
// - clipper drops top four bits giving 24-bit -1 to 1-lsb
// - fixed budget of 1024 instruction cycles per sample period
// - reduced instructions per sample allows double or quad rate
// - default program passes inputs to outputs, outputs muted
// - double precision with 56-bit intermediate data
// - core values are two's complement
// - parameter words padded with four zeros to 32 bits
`timescale 1ns/100ps
`include "audio_dsp_defines.vh"

module audio_dsp_core
#(
  parameter INSTR_PER_SAMPLE = `INSTR_PER_SAMPLE
)
(
  input wire mclk,
  input wire reset,
  input wire [23:0] inSample,
  input wire inValid,
  output wire inReady,
  input wire [31:0] gainParam,
  input wire [1:0] rateSel,
  input wire muteN,
  output reg [23:0] outSample,
  output reg outValid,
  input wire outReady,
  output reg clipped,
  output reg [10:0] instrCount,
  output reg sampleTick
);

  // ===========================================================
  // pin-level controls pass a two-flop synchroniser
  reg [1:0] rateMeta_q;
  reg [1:0] rate_q;
  reg muteMeta_q;
  reg muteN_q;

  // rate and mute are quasi-static, so a plain two-flop sync is enough
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      rateMeta_q <= 2'h0;
      rate_q <= 2'h0;
      muteMeta_q <= 1'b0;
      muteN_q <= 1'b0;
    end
    else
    begin
      rateMeta_q <= rateSel;
      rate_q <= rateMeta_q;
      muteMeta_q <= muteN;
      muteN_q <= muteMeta_q;
    end
  end

  // ===========================================================
  // instruction budget
  reg [10:0] budget;

  // fewer instructions per sample means a faster sample rate
  always @*
  begin
    case (rate_q)
      `RATE_DOUBLE: budget = INSTR_PER_SAMPLE[11:1];
      `RATE_QUAD: budget = {1'b0, INSTR_PER_SAMPLE[11:2]};
      default: budget = INSTR_PER_SAMPLE[10:0];
    endcase
  end

  // one sample accepted per period, at the first instruction slot
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      instrCount <= 11'h000;
      sampleTick <= 1'b0;
    end
    else if (instrCount >= budget - 11'h001)
    begin
      instrCount <= 11'h000;
      sampleTick <= 1'b1;
    end
    else
    begin
      instrCount <= instrCount + 11'h001;
      sampleTick <= 1'b0;
    end
  end

  // ===========================================================
  // sign extension of the incoming word into the core width
  wire [27:0] inCore;
  genvar g;

  // the low 24 bits pass as they are
  assign inCore[23:0] = inSample;

  // each headroom bit repeats the audio sign bit
  generate
    for (g = 0; g < `HEAD_BITS; g = g + 1)
    begin : headBit
      assign inCore[`AUDIO_W + g] = inSample[`AUDIO_W - 1];
    end
  endgenerate

  // ===========================================================
  // coefficient and full-precision product
  wire [27:0] coef;
  wire signed [55:0] product;

  // upper four parameter bits are zero padding and ignored
  assign coef = gainParam[27:0];

  // a 28 by 28 signed product needs all 56 bits, no guard lost;
  // both operands signed keeps the result two's complement
  assign product = $signed(inCore) * $signed(coef);

  // ===========================================================
  // realign to 5.23 and saturate to the core range
  reg signed [55:0] realigned;
  reg coreOvf;
  reg [27:0] scaled;

  // the product carries 46 fraction bits; dropping 23 of them
  // truncates toward minus infinity, which costs under one lsb;
  // a product beyond the core range saturates rather than wraps
  always @*
  begin
    realigned = product >>> `FRAC_BITS;
    coreOvf = (realigned[55:27] != {29{realigned[27]}});
    if (!coreOvf)
    begin
      scaled = realigned[27:0];
    end
    else if (realigned[55])
    begin
      scaled = `CORE_MIN;
    end
    else
    begin
      scaled = `CORE_MAX;
    end
  end

  // ===========================================================
  // output clipper: drop the headroom bits, saturating
  reg clipHit;
  reg [23:0] clipVal;

  // in range only when the top five bits all agree with the sign;
  // a word of exactly +1.0 already needs the fifth bit, so it clips
  always @*
  begin
    clipHit = (scaled[27:23] != {5{scaled[23]}});
    if (!clipHit)
    begin
      clipVal = scaled[23:0];
    end
    else if (scaled[27])
    begin
      clipVal = `OUT_MIN;
    end
    else
    begin
      clipVal = `OUT_MAX;
    end
  end

  // ===========================================================
  // mute stage
  reg [23:0] outWord;
  reg outClip;

  // muted by default until the mute pin releases; a muted word is
  // silence, so it never reports a clip either
  always @*
  begin
    if (muteN_q)
    begin
      outWord = clipVal;
      outClip = clipHit;
    end
    else
    begin
      outWord = 24'h000000;
      outClip = 1'b0;
    end
  end

  // ===========================================================
  // two-entry skid buffer so a stalled receiver loses no word
  reg [23:0] buf0_q;
  reg [23:0] buf1_q;
  reg clip0_q;
  reg clip1_q;
  reg [1:0] count_q;
  reg [23:0] buf0_d;
  reg [23:0] buf1_d;
  reg clip0_d;
  reg clip1_d;
  reg [1:0] count_d;
  wire take;
  wire give;

  // input is only offered on the sample tick; a full buffer
  // refuses it, which costs that sample rather than a stored one
  assign inReady = (count_q != 2'h2) && sampleTick;
  assign take = inValid && inReady;
  assign give = (count_q != 2'h0) && outReady;

  // buf0 is the head; buf1 holds the word behind it
  // a word popped from buf1 leaves a stale copy there, never shown
  always @*
  begin
    buf0_d = buf0_q;
    buf1_d = buf1_q;
    clip0_d = clip0_q;
    clip1_d = clip1_q;
    count_d = count_q;
    case ({take, give})
      2'b10:
      begin
        if (count_q == 2'h0)
        begin
          buf0_d = outWord;
          clip0_d = outClip;
        end
        else
        begin
          buf1_d = outWord;
          clip1_d = outClip;
        end
        count_d = count_q + 2'h1;
      end
      2'b01:
      begin
        buf0_d = buf1_q;
        clip0_d = clip1_q;
        count_d = count_q - 2'h1;
      end
      2'b11:
      begin
        if (count_q == 2'h1)
        begin
          buf0_d = outWord;
          clip0_d = outClip;
        end
        else
        begin
          buf0_d = buf1_q;
          clip0_d = clip1_q;
          buf1_d = outWord;
          clip1_d = outClip;
        end
      end
      default:
      begin
        count_d = count_q;
      end
    endcase
  end

  // buffer state flops
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      buf0_q <= 24'h000000;
      buf1_q <= 24'h000000;
      clip0_q <= 1'b0;
      clip1_q <= 1'b0;
      count_q <= 2'h0;
    end
    else
    begin
      buf0_q <= buf0_d;
      buf1_q <= buf1_d;
      clip0_q <= clip0_d;
      clip1_q <= clip1_d;
      count_q <= count_d;
    end
  end

  // presented word comes straight from the buffer head flops;
  // the word stands until the receiver takes it
  always @*
  begin
    outSample = buf0_q;
    outValid = (count_q != 2'h0);
    clipped = (count_q != 2'h0) && clip0_q;
  end

endmodule // audio_dsp_core

// file: rtl/audio_dsp_defines.vh
// constants shared by the audio number-format core
`ifndef AUDIO_DSP_DEFINES_VH
`define AUDIO_DSP_DEFINES_VH
`define AUDIO_W 24
`define CORE_W 28
`define FRAC_BITS 23
`define HEAD_BITS 4
`define PARAM_W 32
`define ACC_W 56
`define INSTR_PER_SAMPLE 1024
`define RATE_SINGLE 2'h0
`define RATE_DOUBLE 2'h1
`define RATE_QUAD 2'h2
`define OUT_MAX 24'h7fffff
`define OUT_MIN 24'h800000
`define CORE_MAX 28'h7ffffff
`define CORE_MIN 28'h8000000
`define CORE_ONE 28'h0800000
`endif

// file: test/audio_dsp_core_assertions.sv
// checker for the audio number-format core
`timescale 1ns/100ps
module audio_dsp_core_assertions #(parameter INSTR_PER_SAMPLE = 1024)
(input wire mclk, reset, inValid, inReady, muteN, outValid, outReady,
 input wire clipped, sampleTick, input wire [23:0] inSample, outSample,
 input wire [31:0] gainParam, input wire [1:0] rateSel,
 input wire [10:0] instrCount);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence stall_s; outValid && !outReady; endsequence
  sequence mute_take_s; !muteN [*3] ##0 inValid && inReady && !outValid;
  endsequence
  a_ready_tick: assert property (
    inReady |-> sampleTick && instrCount == 11'h000)
    else $error("ready off tick");
  a_tick_pulse: assert property (sampleTick |=> !sampleTick)
    else $error("tick too long");
  a_count_bound: assert property (instrCount < INSTR_PER_SAMPLE)
    else $error("count past budget");
  a_hold_word: assert property (
    stall_s |=> outValid && $stable(outSample))
    else $error("word lost in stall");
  a_take_valid: assert property (inValid && inReady |=> outValid)
    else $error("no output");
  a_clip_max: assert property (
    outValid && clipped && outSample != 0 && !outSample[23] |->
    outSample == 24'h7fffff)
    else $error("bad top clip");
  a_clip_min: assert property (
    outValid && clipped && outSample[23] |-> outSample == 24'h800000)
    else $error("bad low clip");
  a_mute_zero: assert property (mute_take_s |=> outSample == 0)
    else $error("mute leaks");
endmodule // audio_dsp_core_assertions
bind audio_dsp_core audio_dsp_core_assertions
  #(.INSTR_PER_SAMPLE(INSTR_PER_SAMPLE)) chk (.mclk(mclk), .reset(reset),
  .inValid(inValid), .inReady(inReady), .muteN(muteN), .outValid(outValid),
  .outReady(outReady), .clipped(clipped), .sampleTick(sampleTick),
  .inSample(inSample), .outSample(outSample), .gainParam(gainParam),
  .rateSel(rateSel), .instrCount(instrCount));

// file: test/audio_sink.sv
// receiver model that can stall the output stream
`timescale 1ns/100ps
module audio_sink
(
  input wire mclk,
  input wire stall,
  output reg outReady = 1'b0
);
  // ready follows a stall one edge late, as a real sink would
  always @(posedge mclk)
  begin
    outReady <= !stall;
  end
endmodule // audio_sink

// file: test/tb.sv
// self-checking bench for the audio number-format core
`timescale 1ns/100ps
`define CHK(n,e,a) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module tb;
  reg mclk = 0, reset = 1, inValid = 0, muteN = 1, stall = 0;
  reg [23:0] inSample = 0;
  reg [31:0] gainParam = 32'h00800000;
  reg [1:0] rateSel = 0;
  wire inReady, outValid, outReady, clipped, sampleTick;
  wire [23:0] outSample;
  wire [10:0] instrCount;
  integer fails = 0, num_checks = 0, i, n;
  localparam BUDGET = 16;
  // input, gain, expected output, expected clip flag
  reg [80:0] rows [0:5] = '{
    {24'h123456, 32'h00800000, 24'h123456, 1'b0},
    {24'h400000, 32'h01000000, 24'h7fffff, 1'b1},
    {24'hc00000, 32'h02000000, 24'h800000, 1'b1},
    {24'h200000, 32'h00400000, 24'h100000, 1'b0},
    {24'hffffff, 32'h00400000, 24'hffffff, 1'b0},
    {24'h100000, 32'h0f800000, 24'hf00000, 1'b0}};
  audio_dsp_core #(.INSTR_PER_SAMPLE(BUDGET)) uut (.mclk(mclk),
    .reset(reset), .inSample(inSample), .inValid(inValid),
    .inReady(inReady), .gainParam(gainParam), .rateSel(rateSel),
    .muteN(muteN), .outSample(outSample), .outValid(outValid),
    .outReady(outReady), .clipped(clipped), .instrCount(instrCount),
    .sampleTick(sampleTick));
  audio_sink sink (.mclk(mclk), .stall(stall), .outReady(outReady));
  initial forever #4 mclk = ~mclk;
  task print_verdict;
  begin
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // level request held until a tick edge takes it
  task send(input [23:0] s, input [31:0] g);
  begin
    inSample <= s;
    gainParam <= g;
    inValid <= 1;
    @(posedge mclk);
    while (!inReady) @(posedge mclk);
    inValid <= 0;
  end
  endtask
  // waits for a word, checks it, then holds until the sink takes it
  task expect_out(input [23:0] e, input c);
  begin
    @(negedge mclk);
    while (!outValid) @(negedge mclk);
    `CHK("outSample", e, outSample)
    `CHK("clipped", c, clipped)
    @(posedge mclk);
    while (!outReady) @(posedge mclk);
  end
  endtask
  // sets a rate, lets it settle, then counts one tick period into n
  task period_of(input [1:0] r);
  begin
    rateSel <= r;
    repeat (40) @(posedge mclk);
    while (!sampleTick) @(posedge mclk);
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (!sampleTick);
  end
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    `CHK("outValid", 1'b0, outValid)
    reset <= 0;
    for (i = 0; i < 6; i++)
    begin
      send(rows[i][80:57], rows[i][56:25]);
      expect_out(rows[i][24:1], rows[i][0]);
    end
    stall <= 1;
    send(24'h000111, 32'h00800000);
    @(posedge mclk);
    send(24'h000222, 32'h00800000);
    @(negedge mclk);
    while (!sampleTick) @(negedge mclk);
    `CHK("inReady", 1'b0, inReady)
    @(posedge mclk);
    stall <= 0;
    expect_out(24'h000111, 1'b0);
    expect_out(24'h000222, 1'b0);
    muteN <= 0;
    repeat (3) @(posedge mclk);
    send(24'h010000, 32'h00800000);
    expect_out(24'h000000, 1'b0);
    period_of(2'h1);
    `CHK("period", BUDGET / 2, n)
    period_of(2'h2);
    `CHK("period", BUDGET / 4, n)
    period_of(2'h3);
    `CHK("period", BUDGET, n)
    reset <= 1;
    @(negedge mclk);
    `CHK("instrCount", 11'h000, instrCount)
    `CHK("outValid", 1'b0, outValid)
    print_verdict;
  end
  // watchdog: whole run needs a few hundred cycles
  initial
  begin
    #100000;
    fails++;
    print_verdict;
  end
endmodule // tb
